// >>> verilog/ppa_regs.svh
// Register offsets, fields, reset values and timing counts
`ifndef PPA_REGS_SVH
`define PPA_REGS_SVH

`define PPA_ADDR_W 12
`define PPA_CTRL_OFF 12'h000
`define PPA_STATUS_OFF 12'h004
`define PPA_IRQ_STAT_OFF 12'h008
`define PPA_IRQ_CLR_OFF 12'h00C
`define PPA_IRQ_EN_OFF 12'h010
`define PPA_POWER_OFF 12'h014

`define PPA_CTRL_FSEL_LO 0
`define PPA_CTRL_FSEL_HI 1
`define PPA_CTRL_CALSEL 2
`define PPA_CTRL_RST 3'h0

`define PPA_ST_SUPPLY 0
`define PPA_ST_NEG 1

`define PPA_IRQ_W 4
`define PPA_IRQ_CALIB 0
`define PPA_IRQ_SLOW 1
`define PPA_IRQ_SUP_LOST 2
`define PPA_IRQ_SUP_GOOD 3
`define PPA_IRQ_RST 4'h0

`define PPA_ADC_BITS 16
`define PPA_SAMPLE_HZ 450000

`define PPA_SLOW_TH0 48'h0400_0000_0000
`define PPA_SLOW_TH1 48'h0200_0000_0000
`define PPA_SLOW_TH2 48'h0100_0000_0000
`define PPA_SLOW_TH3 48'h0080_0000_0000
`define PPA_CAL_SHIFT_SCF0 11
`define PPA_CAL_SHIFT_SCF1 7

`define PPA_CLK_NS 10
`define PPA_SUP_ON_NS 20000
`define PPA_SUP_OFF_NS 5000
`define PPA_PULSE_NS 1000
`define PPA_SUP_ON_CYC ((`PPA_SUP_ON_NS + `PPA_CLK_NS - 1) / `PPA_CLK_NS)
`define PPA_SUP_OFF_CYC ((`PPA_SUP_OFF_NS + `PPA_CLK_NS - 1) / `PPA_CLK_NS)
`define PPA_PULSE_CYC ((`PPA_PULSE_NS + `PPA_CLK_NS - 1) / `PPA_CLK_NS)

`endif

// >>> verilog/ppa_pkg.sv
// Types shared by the accumulator design
package ppa_pkg;

  typedef struct packed {
    logic signed [15:0] current_channel;
    logic signed [15:0] voltage_channel;
  } ppa_sample_type;

  typedef enum logic {
    SUP_DOWN,
    SUP_UP
  } ppa_supply_state_type;

endpackage

// >>> verilog/ppa_iir.sv
// First-order recursive smoothing filter
`timescale 1ns/1ps
module ppa_iir #(
  parameter int W = 16,
  parameter int SHIFT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_data,
  output logic signed [W-1:0] out_data,
  output logic out_valid
);
  localparam int AW = W + SHIFT;

  logic signed [AW-1:0] acc_reg;
  logic signed [AW:0] diff;

  // Fraction bits keep small steps from being lost
  assign out_data = acc_reg[AW-1:SHIFT];
  assign diff = (AW+1)'(in_data) - (AW+1)'(out_data);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= '0;
    end else if (clear) begin
      acc_reg <= '0;
    end else if (in_valid) begin
      acc_reg <= AW'(acc_reg + diff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid & ~clear;
    end
  end

  property p_iir_step;
    @(posedge pclk) disable iff (!presetn)
    (in_valid && !clear && in_data > out_data) |=> out_data >= $past(out_data);
  endproperty
  a_iir_step: assert property (p_iir_step) else $error("filter stepped away"); // see R4

endmodule

// >>> verilog/ppa_top.sv
// Positive power accumulator with pulse outputs and APB registers
// Behaviour
// R1 - Samples are taken as 16-bit current and voltage pairs at 450 kHz.
// R2 - The current samples pass a high-pass filter that removes dc.
// R3 - Each sample the filtered current is multiplied by the voltage.
// R4 - The product is low-pass filtered to give real power.
// R5 - Only positive real power is added into the pulse accumulators.
// R6 - The slow outputs fire from a long accumulation of positive power.
// R7 - The calibration output uses a much shorter accumulation period.
// R8 - Below the supply trigger level the logic is inactive, no pulses.
// R9 - Supply good is filtered with hysteresis against a noisy supply.
// R10 - The negative flag follows the sign and changes only at calib events; the code also clears it when supply good drops.
// R11 - The outside party picks the slow and calibration frequencies.
// R12 - Going inactive clears accumulators and holds outputs idle.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ppa_regs.svh"
module ppa_top #(
  parameter int HPF_SHIFT = 8,
  parameter int LPF_SHIFT = 10,
  parameter int ACC_W = 48,
  parameter int SUP_ON_CYC = `PPA_SUP_ON_CYC,
  parameter int SUP_OFF_CYC = `PPA_SUP_OFF_CYC,
  parameter int PULSE_CYC = `PPA_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PPA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire ppa_pkg::ppa_sample_type sample,
  input wire logic supply_ok_raw,
  output logic slow_pulse_out_a,
  output logic slow_pulse_out_b,
  output logic calib_pulse_out,
  output logic negative_power_flag,
  output logic irq
);
  localparam int PW = 2 * `PPA_ADC_BITS + 1;

  ppa_pkg::ppa_supply_state_type sup_state_reg;
  logic [11:0] sup_cnt_reg;
  logic sup_good_reg;
  logic sup_good_d_reg;
  logic [2:0] ctrl_reg;
  logic [`PPA_IRQ_W-1:0] irq_stat_reg;
  logic [`PPA_IRQ_W-1:0] irq_en_reg;
  logic [`PPA_IRQ_W-1:0] irq_ev;
  logic [`PPA_IRQ_W-1:0] irq_clr;
  logic [31:0] rd_next;
  logic miss_next;
  logic wr_en;
  logic signed [15:0] dc_est;
  logic signed [16:0] hp_reg;
  logic signed [15:0] volt_reg;
  logic hp_valid_reg;
  logic signed [PW-1:0] prod_reg;
  logic prod_valid_reg;
  logic signed [PW-1:0] power;
  logic power_valid;
  logic power_pos;
  logic power_neg;
  logic [ACC_W-1:0] add_pos;
  logic [ACC_W-1:0] add_neg;
  logic [ACC_W-1:0] slow_acc_reg;
  logic [ACC_W-1:0] calib_acc_reg;
  logic [ACC_W-1:0] neg_acc_reg;
  logic [ACC_W-1:0] slow_sum;
  logic [ACC_W-1:0] calib_sum;
  logic [ACC_W-1:0] neg_sum;
  logic [ACC_W-1:0] slow_th;
  logic [ACC_W-1:0] calib_th;
  logic slow_fire;
  logic calib_fire;
  logic neg_fire;
  logic slow_phase_reg;
  logic neg_flag_reg;
  logic irq_reg;
  logic [2:0] fire;
  logic [2:0] pulse_reg;

  // Supply monitor: a level must persist before it is believed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_state_reg <= ppa_pkg::SUP_DOWN;
      sup_cnt_reg <= 12'h000;
    end else begin
      case (sup_state_reg)
        ppa_pkg::SUP_DOWN: begin
          if (!supply_ok_raw) begin
            sup_cnt_reg <= 12'h000;
          end else if (sup_cnt_reg == 12'(SUP_ON_CYC - 1)) begin // see R9
            sup_state_reg <= ppa_pkg::SUP_UP;
            sup_cnt_reg <= 12'h000;
          end else begin
            sup_cnt_reg <= sup_cnt_reg + 12'h001;
          end
        end
        ppa_pkg::SUP_UP: begin
          if (supply_ok_raw) begin
            sup_cnt_reg <= 12'h000;
          end else if (sup_cnt_reg == 12'(SUP_OFF_CYC - 1)) begin // see R9
            sup_state_reg <= ppa_pkg::SUP_DOWN;
            sup_cnt_reg <= 12'h000;
          end else begin
            sup_cnt_reg <= sup_cnt_reg + 12'h001;
          end
        end
        default: begin
          sup_state_reg <= ppa_pkg::SUP_DOWN;
          sup_cnt_reg <= 12'h000;
        end
      endcase
    end
  end

  assign sup_good_reg = (sup_state_reg == ppa_pkg::SUP_UP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_good_d_reg <= 1'b0;
    end else begin
      sup_good_d_reg <= sup_good_reg;
    end
  end

  // Front end: dc tracker on the current channel
  ppa_iir #(.W(16), .SHIFT(HPF_SHIFT)) u_hpf (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!sup_good_reg),
    .in_valid(sample_valid),
    .in_data(sample.current_channel),
    .out_data(dc_est),
    .out_valid()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_reg <= 17'h00000;
      volt_reg <= 16'h0000;
      hp_valid_reg <= 1'b0;
    end else begin
      hp_valid_reg <= sample_valid & sup_good_reg; // see R1
      if (sample_valid) begin
        hp_reg <= 17'(sample.current_channel) - 17'(dc_est); // see R2
        volt_reg <= sample.voltage_channel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prod_reg <= '0;
      prod_valid_reg <= 1'b0;
    end else begin
      prod_valid_reg <= hp_valid_reg & sup_good_reg;
      if (hp_valid_reg) begin
        // Widen before multiplying so the product keeps all its bits
        prod_reg <= PW'(hp_reg) * PW'(volt_reg); // see R3
      end
    end
  end

  ppa_iir #(.W(PW), .SHIFT(LPF_SHIFT)) u_lpf ( // see R4
    .pclk(pclk),
    .presetn(presetn),
    .clear(!sup_good_reg),
    .in_valid(prod_valid_reg),
    .in_data(prod_reg),
    .out_data(power),
    .out_valid(power_valid)
  );

  // Digital-to-frequency stage
  assign power_pos = power > 0; // see R5
  assign power_neg = power < 0;
  assign add_pos = power_pos ? ACC_W'(unsigned'(power)) : '0; // see R5
  assign add_neg = power_neg ? ACC_W'(unsigned'(PW'(-power))) : '0;

  always_comb begin
    case (ctrl_reg[`PPA_CTRL_FSEL_HI:`PPA_CTRL_FSEL_LO]) // see R11
      2'h0: slow_th = `PPA_SLOW_TH0;
      2'h1: slow_th = `PPA_SLOW_TH1;
      2'h2: slow_th = `PPA_SLOW_TH2;
      default: slow_th = `PPA_SLOW_TH3;
    endcase
  end

  // Short calibration period is the slow one shifted down by 11 or 7 bits, as CALSEL picks
  assign calib_th = ctrl_reg[`PPA_CTRL_CALSEL] ?
    (slow_th >> `PPA_CAL_SHIFT_SCF1) : (slow_th >> `PPA_CAL_SHIFT_SCF0); // see R7
  assign slow_sum = slow_acc_reg + add_pos;
  assign calib_sum = calib_acc_reg + add_pos;
  assign neg_sum = neg_acc_reg + add_neg;
  assign slow_fire = power_valid & sup_good_reg & (slow_sum >= slow_th); // see R6
  assign calib_fire = power_valid & sup_good_reg & (calib_sum >= calib_th);
  assign neg_fire = power_valid & sup_good_reg & (neg_sum >= calib_th);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_acc_reg <= '0;
      calib_acc_reg <= '0;
      neg_acc_reg <= '0;
    end else if (!sup_good_reg) begin
      slow_acc_reg <= '0; // see R12
      calib_acc_reg <= '0;
      neg_acc_reg <= '0;
    end else if (power_valid) begin
      slow_acc_reg <= slow_fire ? slow_sum - slow_th : slow_sum; // see R6
      calib_acc_reg <= calib_fire ? calib_sum - calib_th : calib_sum; // see R7
      neg_acc_reg <= neg_fire ? neg_sum - calib_th : neg_sum;
    end
  end

  // Sign flag moves only when a calibration-rate event happens or supply good drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_flag_reg <= 1'b0;
    end else if (!sup_good_reg) begin
      neg_flag_reg <= 1'b0; // see R12
    end else if (calib_fire) begin
      neg_flag_reg <= 1'b0; // see R10
    end else if (neg_fire) begin
      neg_flag_reg <= 1'b1; // see R10
    end
  end

  // Slow pulses alternate between the two pins for a two-phase stepper
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_phase_reg <= 1'b0;
    end else if (!sup_good_reg) begin
      slow_phase_reg <= 1'b0;
    end else if (slow_fire && !neg_flag_reg) begin
      slow_phase_reg <= ~slow_phase_reg;
    end
  end

  assign fire[0] = calib_fire;
  assign fire[1] = slow_fire & ~neg_flag_reg & ~slow_phase_reg;
  assign fire[2] = slow_fire & ~neg_flag_reg & slow_phase_reg;

  // A new event restarts a running pulse; rates stay far below the limit
  for (genvar g = 0; g < 3; g++) begin : g_pulse
    logic [11:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= 12'h000;
        pulse_reg[g] <= 1'b0;
      end else if (!sup_good_reg) begin
        cnt_reg <= 12'h000; // see R8
        pulse_reg[g] <= 1'b0;
      end else if (fire[g]) begin
        cnt_reg <= 12'(PULSE_CYC - 1);
        pulse_reg[g] <= 1'b1;
      end else if (cnt_reg != 12'h000) begin
        cnt_reg <= cnt_reg - 12'h001;
      end else begin
        pulse_reg[g] <= 1'b0;
      end
    end
  end

  assign calib_pulse_out = pulse_reg[0];
  assign slow_pulse_out_a = pulse_reg[1];
  assign slow_pulse_out_b = pulse_reg[2];
  assign negative_power_flag = neg_flag_reg;

  // APB slave: one wait-free access phase, answer prepared at setup
  assign wr_en = psel & penable & pwrite & pready;
  assign irq_clr = (wr_en && paddr == `PPA_IRQ_CLR_OFF) ?
    pwdata[`PPA_IRQ_W-1:0] : '0;

  always_comb begin
    rd_next = 32'h0000_0000;
    miss_next = 1'b0;
    if (paddr == `PPA_CTRL_OFF) begin
      rd_next = {29'h0, ctrl_reg};
    end else if (paddr == `PPA_STATUS_OFF) begin
      rd_next = {30'h0, neg_flag_reg, sup_good_reg};
    end else if (paddr == `PPA_IRQ_STAT_OFF) begin
      rd_next = {28'h0, irq_stat_reg};
    end else if (paddr == `PPA_IRQ_CLR_OFF) begin
      rd_next = 32'h0000_0000;
    end else if (paddr == `PPA_IRQ_EN_OFF) begin
      rd_next = {28'h0, irq_en_reg};
    end else if (paddr == `PPA_POWER_OFF) begin
      rd_next = power[PW-1:1];
    end else begin
      miss_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= miss_next;
      prdata <= pwrite ? 32'h0000_0000 : rd_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PPA_CTRL_RST;
      irq_en_reg <= `PPA_IRQ_RST;
    end else if (wr_en && paddr == `PPA_CTRL_OFF) begin
      ctrl_reg <= pwdata[2:0];
    end else if (wr_en && paddr == `PPA_IRQ_EN_OFF) begin
      irq_en_reg <= pwdata[`PPA_IRQ_W-1:0];
    end
  end

  // Interrupts: hardware set beats a same-cycle software clear
  assign irq_ev[`PPA_IRQ_CALIB] = calib_fire;
  assign irq_ev[`PPA_IRQ_SLOW] = slow_fire & ~neg_flag_reg;
  assign irq_ev[`PPA_IRQ_SUP_LOST] = sup_good_d_reg & ~sup_good_reg;
  assign irq_ev[`PPA_IRQ_SUP_GOOD] = ~sup_good_d_reg & sup_good_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= `PPA_IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  assign irq = irq_reg;

  property p_sample_taken;
    @(posedge pclk) disable iff (!presetn)
    (sample_valid && sup_good_reg) |=> hp_valid_reg ##1 prod_valid_reg;
  endproperty
  a_sample_taken: assert property (p_sample_taken) else $error("sample lost"); // see R1

  property p_hp_sub;
    @(posedge pclk) disable iff (!presetn)
    sample_valid |=> hp_reg == 17'($past(sample.current_channel))
      - 17'($past(dc_est));
  endproperty
  a_hp_sub: assert property (p_hp_sub) else $error("dc not removed"); // see R2

  property p_product;
    @(posedge pclk) disable iff (!presetn)
    hp_valid_reg |=> prod_reg == PW'($past(hp_reg)) * PW'($past(volt_reg));
  endproperty
  a_product: assert property (p_product) else $error("bad product"); // see R3

  property p_positive_only;
    @(posedge pclk) disable iff (!presetn)
    (sup_good_reg && power_valid && !power_pos && !slow_fire)
      |=> slow_acc_reg == $past(slow_acc_reg);
  endproperty
  a_positive_only: assert property (p_positive_only) else $error("neg added"); // see R5

  property p_slow_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(slow_pulse_out_a) |-> $past(slow_fire) && !$past(neg_flag_reg);
  endproperty
  a_slow_cause: assert property (p_slow_cause) else $error("stray slow"); // see R6

  property p_calib_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(calib_pulse_out) |-> $past(calib_fire) && $past(calib_th < slow_th);
  endproperty
  a_calib_cause: assert property (p_calib_cause) else $error("stray calib"); // see R7

  property p_idle_low;
    @(posedge pclk) disable iff (!presetn)
    !sup_good_reg |=> !slow_pulse_out_a && !slow_pulse_out_b
      && !calib_pulse_out && !negative_power_flag;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("pulse while idle"); // see R8

  property p_supply_filter;
    @(posedge pclk) disable iff (!presetn)
    $rose(sup_good_reg) |-> $past(supply_ok_raw)
      && $past(sup_cnt_reg) == 12'(SUP_ON_CYC - 1);
  endproperty
  a_supply_filter: assert property (p_supply_filter) else $error("early up"); // see R9

  property p_flag_moment;
    @(posedge pclk) disable iff (!presetn)
    $changed(neg_flag_reg) |-> $past(calib_fire || neg_fire || !sup_good_reg);
  endproperty
  a_flag_moment: assert property (p_flag_moment) else $error("flag moved"); // see R10

  property p_clear_acc;
    @(posedge pclk) disable iff (!presetn)
    !sup_good_reg |=> slow_acc_reg == '0 && calib_acc_reg == '0
      && neg_acc_reg == '0;
  endproperty
  a_clear_acc: assert property (p_clear_acc) else $error("acc kept"); // see R12

endmodule

// >>> verif/ppa_pulse_counter.sv
// Pulse counter model standing on the far side of the pulse outputs
`timescale 1ns/1ps
module ppa_pulse_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow_a,
  input wire logic slow_b,
  input wire logic calib,
  output int slow_cnt,
  output int calib_cnt,
  output int order_err,
  output int calib_width
);
  logic a_q;
  logic b_q;
  logic c_q;
  logic last_b;
  int run;
  // A two-phase stepper only advances when the phases alternate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      c_q <= 1'b0;
      last_b <= 1'b1;
      slow_cnt <= 0;
      calib_cnt <= 0;
      order_err <= 0;
      calib_width <= 0;
      run <= 0;
    end else begin
      a_q <= slow_a;
      b_q <= slow_b;
      c_q <= calib;
      if (slow_a && !a_q) begin
        slow_cnt <= slow_cnt + 1;
        last_b <= 1'b0;
        if (!last_b) order_err <= order_err + 1;
      end
      if (slow_b && !b_q) begin
        slow_cnt <= slow_cnt + 1;
        last_b <= 1'b1;
        if (last_b) order_err <= order_err + 1;
      end
      if (calib && !c_q) calib_cnt <= calib_cnt + 1;
      // Width is latched at the falling edge, so merged pulses show up long
      if (calib) begin
        run <= run + 1;
      end else if (c_q) begin
        calib_width <= run;
        run <= 0;
      end
    end
  end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the positive power accumulator
`timescale 1ns/1ps
`include "ppa_regs.svh"
module tb;
  localparam int SON = 8;
  localparam int SOFF = 4;
  localparam int PW = 4;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [31:0] d;
    logic err;
  } ppa_row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid = 1'b0;
  ppa_pkg::ppa_sample_type sample = '0;
  logic supply_ok_raw = 1'b0;
  logic slow_a;
  logic slow_b;
  logic calib;
  logic neg_flag;
  logic irq;
  int slow_cnt;
  int calib_cnt;
  int order_err;
  int calib_width;
  int errors = 0;
  int cmp_count = 0;
  int s0;
  int c0;
  logic [31:0] rd;
  logic er;
  // Reads carry the expected data in d, writes the data to send
  ppa_row_type rows [10] = '{
    '{1'b0, `PPA_CTRL_OFF, 32'h0, 1'b0},
    '{1'b1, `PPA_CTRL_OFF, 32'h7, 1'b0},
    '{1'b0, `PPA_CTRL_OFF, 32'h7, 1'b0},
    '{1'b1, `PPA_CTRL_OFF, 32'h0, 1'b0},
    '{1'b0, `PPA_IRQ_EN_OFF, 32'h0, 1'b0},
    '{1'b0, `PPA_IRQ_CLR_OFF, 32'h0, 1'b0},
    '{1'b1, `PPA_STATUS_OFF, 32'hFFFF, 1'b0},
    '{1'b0, `PPA_STATUS_OFF, 32'h0, 1'b0},
    '{1'b0, 12'h018, 32'h0, 1'b1},
    '{1'b1, 12'h100, 32'h5, 1'b1}};

  ppa_top #(.SUP_ON_CYC(SON), .SUP_OFF_CYC(SOFF), .PULSE_CYC(PW)) ppa_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample(sample), .supply_ok_raw(supply_ok_raw),
    .slow_pulse_out_a(slow_a), .slow_pulse_out_b(slow_b),
    .calib_pulse_out(calib), .negative_power_flag(neg_flag), .irq(irq));

  ppa_pulse_counter ppa_pulse_counter_i (
    .pclk(pclk), .presetn(presetn), .slow_a(slow_a), .slow_b(slow_b),
    .calib(calib), .slow_cnt(slow_cnt), .calib_cnt(calib_cnt),
    .order_err(order_err), .calib_width(calib_width));

  always #5 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Current alternates sign so the dc blocker passes it whole
  task automatic run(input logic neg, input int n);
    logic signed [15:0] c;
    for (int i = 0; i < n; i++) begin
      c = i[0] ? 16'sh7000 : -16'sh7000;
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample.current_channel <= c;
      sample.voltage_channel <= neg ? -c : c;
      @(posedge pclk);
      sample_valid <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (70000) @(posedge pclk);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check(er, rows[i].err);
      if (!rows[i].wr) check(rd, rows[i].d);
    end
    run(1'b0, 20);
    check(slow_cnt + calib_cnt, 0);
    supply_ok_raw <= 1'b1;
    repeat (SON - 2) @(posedge pclk);
    supply_ok_raw <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, `PPA_STATUS_OFF, 32'h0);
    check(rd, 32'h0);
    supply_ok_raw <= 1'b1;
    repeat (SON + 4) @(posedge pclk);
    apb(1'b0, `PPA_STATUS_OFF, 32'h0);
    check(rd, 32'h1);
    supply_ok_raw <= 1'b0;
    repeat (SOFF - 2) @(posedge pclk);
    supply_ok_raw <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `PPA_STATUS_OFF, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `PPA_IRQ_STAT_OFF, 32'h0);
    check(rd, 32'h8);
    check(irq, 1'b0);
    apb(1'b1, `PPA_IRQ_EN_OFF, 32'h8);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b1, `PPA_IRQ_CLR_OFF, 32'h8);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b0, `PPA_IRQ_STAT_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `PPA_IRQ_EN_OFF, 32'h4);
    apb(1'b1, `PPA_CTRL_OFF, 32'h7);
    run(1'b0, 2500);
    check(slow_cnt > 0, 1);
    check(calib_cnt > 4 * slow_cnt, 1);
    check(order_err, 0);
    check(calib_width, PW);
    check(neg_flag, 1'b0);
    apb(1'b0, `PPA_POWER_OFF, 32'h0);
    check(rd >= 32'h1000_0000 && rd < 32'h2000_0000, 1);
    run(1'b1, 1000);
    s0 = slow_cnt;
    c0 = calib_cnt;
    run(1'b1, 500);
    check(slow_cnt, s0);
    check(calib_cnt, c0);
    check(neg_flag, 1'b1);
    apb(1'b0, `PPA_STATUS_OFF, 32'h0);
    check(rd, 32'h3);
    run(1'b0, 1500);
    check(neg_flag, 1'b0);
    check(calib_cnt > c0, 1);
    check(irq, 1'b0);
    // Only the supply-lost event is unmasked, so irq must wait for it
    supply_ok_raw <= 1'b0;
    repeat (SOFF + 4) @(posedge pclk);
    check({slow_a, slow_b, calib, neg_flag}, 4'h0);
    check(irq, 1'b1);
    apb(1'b0, `PPA_STATUS_OFF, 32'h0);
    check(rd, 32'h0);
    s0 = slow_cnt + calib_cnt;
    run(1'b0, 30);
    check(slow_cnt + calib_cnt, s0);
    check({slow_a, slow_b, calib, neg_flag}, 4'h0);
    print_verdict();
  end
endmodule
